// file: include/cmsr_pkg.sv
// cmsr_pkg: register map, field positions, reset values and timing counts of the msr bank
package cmsr_pkg;
    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int DATA_W = 64;
    localparam int BE_W   = DATA_W / 8;

    // ------------------------------------------------------------------
    // register indices (word addresses on the bus)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] IDX_LAST_BRANCH_SLOT7   = 9'h047;
    localparam logic [ADDR_W-1:0] IDX_FW_UPDATE_TRIGGER   = 9'h079;
    localparam logic [ADDR_W-1:0] IDX_FW_UPDATE_SIGNATURE = 9'h08b;
    localparam logic [ADDR_W-1:0] IDX_PERF_COUNTER_ZERO   = 9'h0c1;
    localparam logic [ADDR_W-1:0] IDX_PERF_COUNTER_ONE    = 9'h0c2;
    localparam logic [ADDR_W-1:0] IDX_BUS_SPEED_CODE      = 9'h0cd;
    localparam logic [ADDR_W-1:0] IDX_MAX_FREQ_COUNT      = 9'h0e7;
    localparam logic [ADDR_W-1:0] IDX_ACTUAL_FREQ_COUNT   = 9'h0e8;
    localparam logic [ADDR_W-1:0] IDX_RANGE_TYPE_CAP      = 9'h0fe;
    localparam logic [ADDR_W-1:0] IDX_L2_CACHE_CONTROL    = 9'h11e;
    localparam logic [ADDR_W-1:0] IDX_FAST_CALL_CS        = 9'h174;
    localparam logic [ADDR_W-1:0] IDX_FAST_CALL_SP        = 9'h175;

    // ------------------------------------------------------------------
    // fields
    // ------------------------------------------------------------------
    localparam int BUS_SPEED_W     = 3;
    localparam logic [2:0] BUS_SPEED_100 = 3'h5;
    localparam logic [2:0] BUS_SPEED_133 = 3'h1;
    localparam logic [2:0] BUS_SPEED_167 = 3'h3;
    localparam int L2_HW_EN_BIT    = 0;
    localparam int L2_ECC_CHK_BIT  = 5;
    localparam int L2_INIT_BIT     = 8;
    localparam int L2_ABSENT_BIT   = 23;
    localparam logic L2_INIT_RESET = 1'b0;
    localparam int BRANCH_FROM_LSB = 0;
    localparam int BRANCH_TO_LSB   = 32;
    localparam int ADDR32_W        = 32;

    // ------------------------------------------------------------------
    // timing and reset values
    // ------------------------------------------------------------------
    localparam int FREQ_DIVIDE  = 1024;
    localparam logic [DATA_W-1:0] REG_RESET = 64'h0;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 64'h0;
    localparam int PERF_COUNTERS = 2;

    // ------------------------------------------------------------------
    // bus handshake states (gray)
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CMSR_IDLE = 2'b00,
        CMSR_ACK  = 2'b01
    } cmsr_bus_state_t;
endpackage

// file: design/cmsr_bank.sv
// cmsr_bank: per-core model-specific register bank behind an avalon-mm slave
//
// Summary of operation
// - bus speed field bits 2:0 read 101b/001b/011b for 100/133/167 MHz; upper zero
// - bus speed register is one shared read-only copy
// - max-frequency count advances once per 1024 max clocks, only when active
// - max-frequency count clears on write to either count and on wrap
// - actual-frequency count advances once per 1024 coordinated clocks, only when active
// - actual-frequency count clears on write to either count
// - cache control bit 0 read-only, shows hardware enable of second-level cache
// - bit 5 read-only, shows data bus error checking, 0 by default
// - check bits always generated on cache write cycles
// - bit 8 read-write, software sets after cache init, resets to 0
// - while bit 8 is 0 write-back-invalidate and flush input are ignored
// - bit 23 read-only, 0 when cache present, 1 when absent
// - firmware update trigger register read-write, one copy per core
// - firmware update signature register read-only, one copy per core
// - branch record holds source in low 32 bits, target in high 32 bits
//
// every access costs two cycles: one wait state, then the accepting edge.
// read data is captured on the first edge, so a register that moves during
// the wait state is returned as it stood when the read began.
// frequency-count writes clear rather than load: the written data is not used.
`timescale 1ns/1ps
`default_nettype none
module cmsr_bank #(
    parameter logic [2:0]  BUS_SPEED_CODE = cmsr_pkg::BUS_SPEED_100,
    parameter logic [63:0] RANGE_CAP_VALUE = 64'h0,
    parameter int          FREQ_DIVIDE     = cmsr_pkg::FREQ_DIVIDE
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    // avalon-mm slave
    input  wire logic [cmsr_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [cmsr_pkg::BE_W-1:0]     avs_byteenable,
    input  wire logic [cmsr_pkg::DATA_W-1:0]   avs_writedata,
    output logic [cmsr_pkg::DATA_W-1:0]        avs_readdata,
    output logic                               avs_waitrequest,
    // core status
    input  wire logic                          core_active,
    input  wire logic                          max_clk_tick,
    input  wire logic                          actual_clk_tick,
    input  wire logic [1:0]                    perf_event,
    input  wire logic                          branch_taken,
    input  wire logic [31:0]                   branch_from,
    input  wire logic [31:0]                   branch_to,
    input  wire logic [63:0]                   fw_signature,
    // second-level cache status and flush control
    input  wire logic                          l2_hw_enabled,
    input  wire logic                          l2_ecc_check_on,
    input  wire logic                          l2_absent,
    input  wire logic                          writeback_invalidate_instruction,
    input  wire logic                          flush_n,
    output logic                               l2_flush_go,
    output logic                               l2_ecc_gen_on_write,
    output logic                               l2_initialized
);
    import cmsr_pkg::*;

    localparam int DIV_W = $clog2(FREQ_DIVIDE);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(FREQ_DIVIDE - 1);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [DATA_W-1:0] merge_bytes(
        input logic [DATA_W-1:0] old_val,
        input logic [DATA_W-1:0] new_val,
        input logic [BE_W-1:0]   be
    );
        logic [DATA_W-1:0] res;
        res = old_val;
        for (int b = 0; b < BE_W; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic wr_hit(
        input logic              wr,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] idx
    );
        return wr && (addr == idx);
    endfunction

    // ------------------------------------------------------------------
    // bus handshake: every access answers on the second edge
    // ------------------------------------------------------------------
    cmsr_bus_state_t bus_state;
    logic            take;
    logic            wr_take;

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_state <= CMSR_IDLE;
        end else begin
            case (bus_state)
                CMSR_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state <= CMSR_ACK;
                    end
                end
                CMSR_ACK: begin
                    bus_state <= CMSR_IDLE;
                end
                default: begin
                    bus_state <= CMSR_IDLE;
                end
            endcase
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && (bus_state != CMSR_ACK);
    assign take            = (avs_read || avs_write) && (bus_state == CMSR_ACK);
    assign wr_take         = take && avs_write;

    // ------------------------------------------------------------------
    // read-write storage; slot 7 also loads on branch capture
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] last_branch_record_slot7;
    logic [DATA_W-1:0] firmware_update_trigger;
    logic [DATA_W-1:0] fast_call_code_segment;
    logic [DATA_W-1:0] fast_call_stack_pointer;
    logic              wr_slot7;
    logic              wr_trigger;
    logic              wr_call_cs;
    logic              wr_call_sp;

    assign wr_slot7   = wr_hit(wr_take, avs_address, IDX_LAST_BRANCH_SLOT7);
    assign wr_trigger = wr_hit(wr_take, avs_address, IDX_FW_UPDATE_TRIGGER);
    assign wr_call_cs = wr_hit(wr_take, avs_address, IDX_FAST_CALL_CS);
    assign wr_call_sp = wr_hit(wr_take, avs_address, IDX_FAST_CALL_SP);

    // a hardware branch capture wins over a software write in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            last_branch_record_slot7 <= REG_RESET;
        end else if (branch_taken) begin
            last_branch_record_slot7 <= {branch_to, branch_from};
        end else if (wr_slot7) begin
            last_branch_record_slot7 <= merge_bytes(last_branch_record_slot7,
                                                    avs_writedata, avs_byteenable);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            firmware_update_trigger <= REG_RESET;
        end else if (wr_trigger) begin
            firmware_update_trigger <= merge_bytes(firmware_update_trigger,
                                                   avs_writedata, avs_byteenable);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fast_call_code_segment <= REG_RESET;
        end else if (wr_call_cs) begin
            fast_call_code_segment <= merge_bytes(fast_call_code_segment,
                                                  avs_writedata, avs_byteenable);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fast_call_stack_pointer <= REG_RESET;
        end else if (wr_call_sp) begin
            fast_call_stack_pointer <= merge_bytes(fast_call_stack_pointer,
                                                   avs_writedata, avs_byteenable);
        end
    end

    // ------------------------------------------------------------------
    // performance counters
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] perf_count [PERF_COUNTERS];

    genvar gi;
    generate
        for (gi = 0; gi < PERF_COUNTERS; gi++) begin : g_perf
            localparam logic [ADDR_W-1:0] MY_IDX = IDX_PERF_COUNTER_ZERO + ADDR_W'(gi);
            always_ff @(posedge clk) begin
                if (rst) begin
                    perf_count[gi] <= REG_RESET;
                end else if (wr_hit(wr_take, avs_address, MY_IDX)) begin
                    perf_count[gi] <= merge_bytes(perf_count[gi], avs_writedata,
                                                  avs_byteenable);
                end else if (perf_event[gi]) begin
                    perf_count[gi] <= perf_count[gi] + 64'h1;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // frequency-ratio counters
    // ------------------------------------------------------------------
    logic [DIV_W-1:0]  max_prescale;
    logic [DIV_W-1:0]  act_prescale;
    logic [DATA_W-1:0] max_count;
    logic [DATA_W-1:0] actual_count;
    logic              ratio_clear;
    logic              max_step;
    logic              act_step;

    // a write to either count restarts both, prescalers included
    assign ratio_clear = wr_hit(wr_take, avs_address, IDX_MAX_FREQ_COUNT)
                       || wr_hit(wr_take, avs_address, IDX_ACTUAL_FREQ_COUNT);
    assign max_step    = core_active && max_clk_tick && (max_prescale == DIV_LAST);
    assign act_step    = core_active && actual_clk_tick && (act_prescale == DIV_LAST);

    always_ff @(posedge clk) begin
        if (rst || ratio_clear) begin
            max_prescale <= '0;
        end else if (core_active && max_clk_tick) begin
            if (max_prescale == DIV_LAST) begin
                max_prescale <= '0;
            end else begin
                max_prescale <= max_prescale + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || ratio_clear) begin
            act_prescale <= '0;
        end else if (core_active && actual_clk_tick) begin
            if (act_prescale == DIV_LAST) begin
                act_prescale <= '0;
            end else begin
                act_prescale <= act_prescale + DIV_W'(1);
            end
        end
    end

    // wrap of the max count lands on zero by plain 64-bit rollover
    always_ff @(posedge clk) begin
        if (rst || ratio_clear) begin
            max_count <= REG_RESET;
        end else if (max_step) begin
            max_count <= max_count + 64'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || ratio_clear) begin
            actual_count <= REG_RESET;
        end else if (act_step) begin
            actual_count <= actual_count + 64'h1;
        end
    end

    // ------------------------------------------------------------------
    // second-level cache control
    // ------------------------------------------------------------------
    logic              l2_init;
    logic [DATA_W-1:0] l2_control_view;
    logic [DATA_W-1:0] l2_wr_merged;

    assign l2_wr_merged = merge_bytes({{(DATA_W-1){1'b0}}, l2_init} << L2_INIT_BIT,
                                      avs_writedata, avs_byteenable);

    // only bit 8 is stored; read-only and reserved write bits fall away
    always_ff @(posedge clk) begin
        if (rst) begin
            l2_init <= L2_INIT_RESET;
        end else if (wr_hit(wr_take, avs_address, IDX_L2_CACHE_CONTROL)) begin
            l2_init <= l2_wr_merged[L2_INIT_BIT];
        end
    end

    always_comb begin
        l2_control_view                = '0;
        l2_control_view[L2_HW_EN_BIT]  = l2_hw_enabled;
        l2_control_view[L2_ECC_CHK_BIT] = l2_ecc_check_on;
        l2_control_view[L2_INIT_BIT]   = l2_init;
        l2_control_view[L2_ABSENT_BIT] = l2_absent;
    end

    // flush requests are dropped, not held, while the cache is not initialized
    always_ff @(posedge clk) begin
        if (rst) begin
            l2_flush_go <= 1'b0;
        end else if (!l2_init) begin
            l2_flush_go <= 1'b0;
        end else begin
            l2_flush_go <= writeback_invalidate_instruction || !flush_n;
        end
    end

    assign l2_ecc_gen_on_write = 1'b1;
    assign l2_initialized      = l2_init;

    // ------------------------------------------------------------------
    // read mux; read-only registers have no write path at all
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] next_readdata;

    always_comb begin
        case (avs_address)
            IDX_LAST_BRANCH_SLOT7:   next_readdata = last_branch_record_slot7;
            IDX_FW_UPDATE_TRIGGER:   next_readdata = firmware_update_trigger;
            IDX_FW_UPDATE_SIGNATURE: next_readdata = fw_signature;
            IDX_PERF_COUNTER_ZERO:   next_readdata = perf_count[0];
            IDX_PERF_COUNTER_ONE:    next_readdata = perf_count[1];
            IDX_BUS_SPEED_CODE:      next_readdata = {61'h0, BUS_SPEED_CODE};
            IDX_MAX_FREQ_COUNT:      next_readdata = max_count;
            IDX_ACTUAL_FREQ_COUNT:   next_readdata = actual_count;
            IDX_RANGE_TYPE_CAP:      next_readdata = RANGE_CAP_VALUE;
            IDX_L2_CACHE_CONTROL:    next_readdata = l2_control_view;
            IDX_FAST_CALL_CS:        next_readdata = fast_call_code_segment;
            IDX_FAST_CALL_SP:        next_readdata = fast_call_stack_pointer;
            default:                 next_readdata = UNMAPPED_READ;
        endcase
    end

    // captured on the first edge of a read so it stands at the accepting edge
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= '0;
        end else if (avs_read && (bus_state == CMSR_IDLE)) begin
            avs_readdata <= next_readdata;
        end
    end
endmodule
`default_nettype wire

// file: verification/cmsr_bank_chk.sv
// cmsr_bank_chk: concurrent checks on the msr bank ports
`timescale 1ns/1ps
`default_nettype none
module cmsr_bank_chk (
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic [cmsr_pkg::ADDR_W-1:0] avs_address,
    input wire logic                        avs_read,
    input wire logic                        avs_write,
    input wire logic [cmsr_pkg::BE_W-1:0]   avs_byteenable,
    input wire logic [cmsr_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [cmsr_pkg::DATA_W-1:0] avs_readdata,
    input wire logic                        avs_waitrequest,
    input wire logic                        l2_hw_enabled,
    input wire logic                        l2_ecc_check_on,
    input wire logic                        l2_absent,
    input wire logic                        writeback_invalidate_instruction,
    input wire logic                        flush_n,
    input wire logic                        l2_flush_go,
    input wire logic                        l2_ecc_gen_on_write,
    input wire logic                        l2_initialized
);
    import cmsr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----
    // read-only status fields
    // ----
    a_speed_code_read: assert property (
        avs_read && !avs_waitrequest && avs_address == IDX_BUS_SPEED_CODE
        |-> avs_readdata == {61'h0, BUS_SPEED_100}) else $error("bus speed code wrong");
    a_cache_status_bits: assert property (
        avs_read && !avs_waitrequest && avs_address == IDX_L2_CACHE_CONTROL
        |-> avs_readdata[0] == $past(l2_hw_enabled) && avs_readdata[5] == $past(l2_ecc_check_on)
            && avs_readdata[23] == $past(l2_absent)) else $error("cache status bits wrong");
    a_ecc_gen_always: assert property (l2_ecc_gen_on_write)
        else $error("check bit generation off");
    // ----
    // cache initialized bit and flush gating
    // ----
    a_init_after_reset: assert property ($fell(rst) |-> !l2_initialized && !l2_flush_go)
        else $error("init bit not cleared by reset");
    a_init_load_bit: assert property (
        avs_write && !avs_waitrequest && avs_address == IDX_L2_CACHE_CONTROL && avs_byteenable[1]
        |=> l2_initialized == $past(avs_writedata[8])) else $error("init bit not written");
    a_init_hold_bit: assert property (
        !(avs_write && !avs_waitrequest && avs_address == IDX_L2_CACHE_CONTROL)
        |=> $stable(l2_initialized)) else $error("init bit changed without write");
    a_flush_gated_off: assert property (!l2_initialized |=> !l2_flush_go)
        else $error("flush honoured before init");
    a_flush_pin_go: assert property (l2_initialized && !flush_n |=> l2_flush_go)
        else $error("flush pin ignored after init");
    a_flush_instr_go: assert property (
        l2_initialized && writeback_invalidate_instruction |=> l2_flush_go)
        else $error("flush instruction ignored after init");
endmodule
`default_nettype wire

// file: verification/cmsr_bank_tb_top.sv
// cmsr_bank_tb_top: directed register, counter and flush tests of the msr bank
`timescale 1ns/1ps
`default_nettype none
module cmsr_bank_tb_top;
    import cmsr_pkg::*;
    localparam int DIV = 4; // short prescaler keeps the counter tests brief
    logic              clk, rst, avs_read, avs_write, avs_waitrequest, core_active;
    logic              max_clk_tick, actual_clk_tick, branch_taken, l2_hw_enabled;
    logic              l2_ecc_check_on, l2_absent, writeback_invalidate_instruction, flush_n;
    logic              l2_flush_go, l2_ecc_gen_on_write, l2_initialized;
    logic [ADDR_W-1:0] avs_address;
    logic [BE_W-1:0]   avs_byteenable;
    logic [DATA_W-1:0] avs_writedata, avs_readdata, rdata, fw_signature;
    logic [31:0]       branch_from, branch_to;
    logic [1:0]        perf_event;
    int                num_errors, checked;
    logic [ADDR_W-1:0] ads [13];

    cmsr_bank #(.FREQ_DIVIDE(DIV)) dut (
        .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .core_active, .max_clk_tick, .actual_clk_tick,
        .perf_event, .branch_taken, .branch_from, .branch_to, .fw_signature, .l2_hw_enabled,
        .l2_ecc_check_on, .l2_absent, .writeback_invalidate_instruction, .flush_n,
        .l2_flush_go, .l2_ecc_gen_on_write, .l2_initialized
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ----
    // bus and compare tasks
    // ----
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until the rising edge that samples waitrequest low; data taken there
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [BE_W-1:0] be);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n == 20) num_errors++;
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        acc(1'b0, a, 64'h0, 8'h00);
        cmp(rdata, e);
    endtask
    task automatic flush(input logic pin, input logic e);
        @(posedge clk);
        if (pin) flush_n <= 1'b0;
        else writeback_invalidate_instruction <= 1'b1;
        @(posedge clk);
        flush_n <= 1'b1;
        writeback_invalidate_instruction <= 1'b0;
        @(negedge clk);
        cmp(l2_flush_go, e);
    endtask
    task automatic tick(input int n, input logic act);
        @(posedge clk);
        core_active <= act;
        max_clk_tick <= 1'b1;
        actual_clk_tick <= 1'b1;
        repeat (n) @(posedge clk);
        {core_active, max_clk_tick, actual_clk_tick} <= 3'h0;
    endtask
    function automatic logic [63:0] ctl(input logic i);
        ctl = 64'h0;
        ctl[0] = l2_hw_enabled;
        ctl[5] = l2_ecc_check_on;
        ctl[8] = i;
        ctl[23] = l2_absent;
    endfunction
    function automatic logic [63:0] ev(input logic [ADDR_W-1:0] a, input logic w);
        case (a)
            IDX_FW_UPDATE_SIGNATURE: ev = fw_signature;
            IDX_BUS_SPEED_CODE: ev = {61'h0, BUS_SPEED_100};
            IDX_L2_CACHE_CONTROL: ev = ctl(1'b0);
            IDX_LAST_BRANCH_SLOT7, IDX_FW_UPDATE_TRIGGER, IDX_FAST_CALL_CS,
            IDX_FAST_CALL_SP: ev = w ? 64'hffffffff_ffffffff : 64'h0;
            default: ev = 64'h0;
        endcase
    endfunction
    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge clk);
        num_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        conclude();
    end
    // ----
    // test sequence
    // ----
    initial begin
        {rst, flush_n, l2_hw_enabled} = 3'h7;
        {avs_read, avs_write, core_active, max_clk_tick, actual_clk_tick} = 5'h0;
        {branch_taken, l2_ecc_check_on, l2_absent, writeback_invalidate_instruction} = 4'h0;
        {avs_address, avs_byteenable, avs_writedata, perf_event} = '0;
        {branch_from, branch_to} = 64'h0;
        fw_signature = 64'h0123_4567_89ab_cdef; // arbitrary value
        ads = '{IDX_LAST_BRANCH_SLOT7, IDX_FW_UPDATE_TRIGGER, IDX_FW_UPDATE_SIGNATURE,
                IDX_BUS_SPEED_CODE, IDX_MAX_FREQ_COUNT, IDX_ACTUAL_FREQ_COUNT,
                IDX_RANGE_TYPE_CAP, IDX_FAST_CALL_CS, IDX_FAST_CALL_SP, 9'h1ff,
                IDX_PERF_COUNTER_ZERO, IDX_PERF_COUNTER_ONE, IDX_L2_CACHE_CONTROL};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (ads[i]) rdc(ads[i], ev(ads[i], 1'b0));
        for (int i = 0; i < 10; i++) begin
            acc(1'b1, ads[i], 64'hffffffff_ffffffff, 8'hff);
            rdc(ads[i], ev(ads[i], 1'b1));
        end
        acc(1'b1, IDX_FW_UPDATE_TRIGGER, 64'h0, 8'h0f);
        rdc(IDX_FW_UPDATE_TRIGGER, 64'hffffffff_00000000);
        @(posedge clk);
        {branch_to, branch_from} <= 64'h9abcdef0_12345678;
        branch_taken <= 1'b1;
        @(posedge clk);
        branch_taken <= 1'b0;
        rdc(IDX_LAST_BRANCH_SLOT7, 64'h9abcdef0_12345678);
        for (int i = 0; i < 2; i++) begin
            {l2_hw_enabled, l2_ecc_check_on, l2_absent} <= (i == 0) ? 3'b110 : 3'b001;
            @(negedge clk);
            rdc(IDX_L2_CACHE_CONTROL, ctl(1'b0));
        end
        flush(1'b1, 1'b0);
        flush(1'b0, 1'b0);
        acc(1'b1, IDX_L2_CACHE_CONTROL, 64'hffffffff_ffffffff, 8'hff);
        rdc(IDX_L2_CACHE_CONTROL, ctl(1'b1));
        cmp(l2_initialized, 1'b1);
        flush(1'b1, 1'b1);
        flush(1'b0, 1'b1);
        cmp(l2_ecc_gen_on_write, 1'b1);
        // ----
        // performance and frequency counters
        // ----
        @(posedge clk);
        perf_event <= 2'b11;
        repeat (2) @(posedge clk) perf_event <= 2'b01;
        @(posedge clk);
        perf_event <= 2'b00;
        rdc(IDX_PERF_COUNTER_ZERO, 64'h3);
        rdc(IDX_PERF_COUNTER_ONE, 64'h1);
        acc(1'b1, IDX_MAX_FREQ_COUNT, 64'h0, 8'hff);
        tick(5 * DIV, 1'b1);
        tick(2 * DIV, 1'b0);
        rdc(IDX_MAX_FREQ_COUNT, 64'h5);
        rdc(IDX_ACTUAL_FREQ_COUNT, 64'h5);
        acc(1'b1, IDX_ACTUAL_FREQ_COUNT, 64'h1, 8'hff);
        rdc(IDX_MAX_FREQ_COUNT, 64'h0);
        rdc(IDX_ACTUAL_FREQ_COUNT, 64'h0);
        tick(2 * DIV, 1'b1);
        rdc(IDX_MAX_FREQ_COUNT, 64'h2);
        acc(1'b1, IDX_MAX_FREQ_COUNT, 64'h1, 8'hff);
        rdc(IDX_ACTUAL_FREQ_COUNT, 64'h0);
        // second reset in mid-run must drop the init bit again
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(IDX_L2_CACHE_CONTROL, ctl(1'b0));
        rdc(IDX_FW_UPDATE_TRIGGER, 64'h0);
        conclude();
    end
endmodule

bind cmsr_bank cmsr_bank_chk chk (
    .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .l2_hw_enabled, .l2_ecc_check_on, .l2_absent,
    .writeback_invalidate_instruction, .flush_n, .l2_flush_go, .l2_ecc_gen_on_write,
    .l2_initialized
);
`default_nettype wire
